// ===== hw/srs_pkg.sv
// constants, opcodes and carrier types of the shift, rotate and sign unit
// assumes a 32-bit apb bus and 24-bit two's complement accumulators
package srs_pkg;

    // -----------------------------------------------------------------
    // data widths
    // -----------------------------------------------------------------
    localparam int ACC_W    = 24;
    localparam int NUM_ACC  = 4;
    localparam int ADDR_W   = 8;
    localparam int PC_W     = 16;
    localparam int CYC_W    = 9;

    // -----------------------------------------------------------------
    // register byte offsets
    // -----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ACC_X    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ACC_Y    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ACC_Z    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ACC_R    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_COMMAND  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PROG_CNT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SKIP_INF = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h20;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int CMD_OP_LSB   = 0;   // opcode [3:0]
    localparam int CMD_SEL_LSB  = 4;   // accumulator select [5:4]
    localparam int CMD_HASC_BIT = 6;   // repeat count present
    localparam int CMD_CNT_LSB  = 8;   // 4-bit count / rounding scale [11:8]
    localparam int CMD_SKIP_LSB = 12;  // skipped line count [13:12]
    localparam int SKI_LEN_W    = 4;   // byte length of each following line
    localparam int SKI_CYC_LSB  = 16;  // cycles of skipped lines [23:16]
    localparam int FLG_C = 0;
    localparam int FLG_O = 1;
    localparam int FLG_S = 2;
    localparam int FLG_Z = 3;

    // -----------------------------------------------------------------
    // opcodes, byte lengths and cycle counts
    // -----------------------------------------------------------------
    localparam logic [3:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 4'h0;
    localparam logic [3:0] OP_LOGICAL_LEFT_SHIFT         = 4'h1;
    localparam logic [3:0] OP_ARITHMETIC_RIGHT_SHIFT     = 4'h2;
    localparam logic [3:0] OP_FORCE_CARRY_HIGH           = 4'h3;
    localparam logic [3:0] OP_SIGN                       = 4'h4;
    localparam logic [3:0] OP_ROUND                      = 4'h5;
    localparam logic [3:0] OP_SKIP                       = 4'h6;
    localparam logic [PC_W-1:0]  BYTES_ONE   = 16'h0001;
    localparam logic [PC_W-1:0]  BYTES_TWO   = 16'h0002;
    localparam logic [PC_W-1:0]  BYTES_ROUND = 16'h0007;
    localparam logic [CYC_W-1:0] CYC_ONE     = 9'h001;
    localparam logic [CYC_W-1:0] CYC_SIGN    = 9'h002;
    localparam logic [ACC_W-1:0] VAL_PLUS1   = 24'h000001;
    localparam logic [ACC_W-1:0] VAL_MINUS1  = 24'hFFFFFF;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] skipLines;
        logic [3:0] count;
        logic       hasCount;
        logic [1:0] accSel;
        logic [3:0] opcode;
    } srs_cmd_s;

    typedef struct packed {
        logic zero;
        logic sign;
        logic overflow;
        logic carry;
    } srs_flags_s;

endpackage : srs_pkg

// ===== hw/srs_shift_rotate_sign_unit.sv
// shift, rotate, sign, rounding and unconditional skip unit with apb registers
// assumes an apb master on the same 40 MHz clock; one command runs at a time
//
// How it works
// RL1: a single right rotate moves carry into the msb and the lsb into carry.
// RL2: a counted right rotate repeats the carry rotate per count and takes 1 + count cycles.
// RL3: shifts and rotates are one byte without a count and two bytes with a 4-bit count.
// RL4: a single left shift fills the lsb with zero, the msb goes to carry, in one cycle.
// RL5: a counted left shift repeats the zero-fill shift with the msb into carry each step.
// RL6: the arithmetic right shift copies the msb into itself once or count times.
// RL7: force carry high sets carry, clears overflow, one byte, one cycle.
// RL8: sign writes +1 for zero or positive, -1 for negative, sets only s and z, 2 bytes, 2 cycles.
// RL9: rounding works on x only, is seven bytes long and runs as a multi-cycle call.
// RL10: rounding goes down below half of the scale step and up at half or more.
// RL11: the skip moves the pc past the byte lengths of the next one to three lines.
// RL12: rotate, shift and sign take any of the accumulators x, y, z or r.
// RL13: a skip takes one cycle plus the cycles of the lines it passes over.
// RL14: 24-bit two's complement; the arithmetic shift puts the lsb in carry and sets c o s z.
`timescale 1ns/1ps

module srs_shift_rotate_sign_unit
    import srs_pkg::*;
#(
    parameter logic [CYC_W-1:0] ROUND_CYCLES = 9'h004
)
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    output logic                   busy
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef enum logic [0:0] {ST_IDLE, ST_EXEC} srs_state_e;

    srs_state_e       state;
    srs_cmd_s         cmd;
    srs_flags_s       flags;
    logic [ACC_W-1:0] acc [NUM_ACC];
    logic [PC_W-1:0]  progCnt;
    logic [31:0]      skipInfo;
    logic [CYC_W-1:0] cyclesLeft;
    logic [4:0]       stepsLeft;
    logic [CYC_W-1:0] lastCycles;
    logic [CYC_W-1:0] runCycles;

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    // word aligned decode; byte offsets inside a word are not mapped
    wire              accessPhase = psel & penable;
    wire              firstAccess = accessPhase & ~pready;
    wire              isAccReg    = (paddr[ADDR_W-1:4] == OFS_ACC_X[ADDR_W-1:4])
                                    & (paddr[1:0] == 2'b00);
    wire              isFlags     = (paddr == OFS_FLAGS);
    wire              isCommand   = (paddr == OFS_COMMAND);
    wire              isProgCnt   = (paddr == OFS_PROG_CNT);
    wire              isSkipInf   = (paddr == OFS_SKIP_INF);
    wire              isStatus    = (paddr == OFS_STATUS);
    wire              isMapped    = isAccReg | isFlags | isCommand | isProgCnt
                                    | isSkipInf | isStatus;
    // writes while a command runs would corrupt its operands, so they are refused
    wire              wrRefused   = pwrite & ((state == ST_EXEC) | isStatus);
    wire              next_err    = ~isMapped | wrRefused;
    wire              wrNow       = accessPhase & pready & pwrite & ~pslverr;
    wire [1:0]        regIdx      = paddr[3:2];

    // read multiplexer
    wire [31:0] accRead   = {{(32-ACC_W){1'b0}}, acc[regIdx]};
    wire [31:0] flgRead   = {28'h0000000, flags};
    wire [31:0] cmdRead   = {18'h00000, cmd[12:11], cmd[10:7], 1'b0, cmd[6:0]};
    wire [31:0] pcRead    = {{(32-PC_W){1'b0}}, progCnt};
    wire [31:0] statRead  = {{(32-1-CYC_W){1'b0}}, lastCycles, (state == ST_EXEC)};
    wire [31:0] next_rdata = isAccReg  ? accRead  :
                             isFlags   ? flgRead  :
                             isCommand ? cmdRead  :
                             isProgCnt ? pcRead   :
                             isSkipInf ? skipInfo :
                             isStatus  ? statRead : 32'h00000000;

    // -----------------------------------------------------------------
    // new command fields
    // -----------------------------------------------------------------
    srs_cmd_s newCmd;
    assign newCmd.opcode    = pwdata[CMD_OP_LSB+:4];
    assign newCmd.accSel    = pwdata[CMD_SEL_LSB+:2];
    assign newCmd.hasCount  = pwdata[CMD_HASC_BIT];
    assign newCmd.count     = pwdata[CMD_CNT_LSB+:4];
    assign newCmd.skipLines = pwdata[CMD_SKIP_LSB+:2];

    // shift class decode, shared by launch timing and the running step
    function automatic logic srs_is_shift(input logic [3:0] op);
        return (op == OP_ROTATE_RIGHT_THROUGH_CARRY) | (op == OP_LOGICAL_LEFT_SHIFT)
             | (op == OP_ARITHMETIC_RIGHT_SHIFT);
    endfunction : srs_is_shift

    wire isShiftOp = srs_is_shift(newCmd.opcode);
    wire launch    = wrNow & isCommand;

    // total cycles of the launched command
    //   RL2 counted shift cycles
    wire [CYC_W-1:0] shiftCyc  = newCmd.hasCount ? CYC_ONE + CYC_W'(newCmd.count) : CYC_ONE;
    //   RL13 skip costs its passed lines
    wire [CYC_W-1:0] skipCyc   = CYC_ONE + CYC_W'(skipInfo[SKI_CYC_LSB+:8]);
    wire [CYC_W-1:0] next_cyc  =
        isShiftOp                         ? shiftCyc     :
        (newCmd.opcode == OP_SIGN)        ? CYC_SIGN     :
        (newCmd.opcode == OP_ROUND)       ? ROUND_CYCLES :
        (newCmd.opcode == OP_SKIP)        ? skipCyc      : CYC_ONE;

    // -----------------------------------------------------------------
    // one shift step
    // -----------------------------------------------------------------
    // returns {carry, value} after a single step of the given opcode
    function automatic logic [ACC_W:0] srs_step(input logic [3:0]       op,
                                                input logic [ACC_W-1:0] v,
                                                input logic             c);
        logic [ACC_W:0] r;
        r = {c, v};
        case (op)
            OP_ROTATE_RIGHT_THROUGH_CARRY: r = {v[0], c, v[ACC_W-1:1]};
            OP_LOGICAL_LEFT_SHIFT:         r = {v[ACC_W-1], v[ACC_W-2:0], 1'b0};
            OP_ARITHMETIC_RIGHT_SHIFT:     r = {v[0], v[ACC_W-1], v[ACC_W-1:1]};
            default:                       r = {c, v};
        endcase
        return r;
    endfunction : srs_step

    // -----------------------------------------------------------------
    // datapath of the running command
    // -----------------------------------------------------------------
    wire [ACC_W-1:0] opVal    = acc[cmd.accSel];
    // RL1 rotate, RL4 left shift, RL6 sign copy
    wire [ACC_W:0]   stepOut  = srs_step(cmd.opcode, opVal, flags.carry);
    wire [ACC_W-1:0] stepVal  = stepOut[ACC_W-1:0];
    // overflow marks a sign change caused by the step
    wire             stepOvf  = stepVal[ACC_W-1] ^ opVal[ACC_W-1];
    wire             isShRun  = srs_is_shift(cmd.opcode);
    wire             doStep   = (state == ST_EXEC) & isShRun & (stepsLeft != 5'h00);
    wire             lastCyc  = (state == ST_EXEC) & (cyclesLeft == CYC_ONE);

    // RL8 sign value, zero counts as positive
    wire [ACC_W-1:0] signVal  = opVal[ACC_W-1] ? VAL_MINUS1 : VAL_PLUS1;

    // RL10 round x to a step of 2^count, half step or more goes up
    wire [ACC_W-1:0] rndMask  = (ACC_W'(1) << cmd.count) - ACC_W'(1);
    wire [ACC_W-1:0] rndHalf  = rndMask - (rndMask >> 1);
    wire [ACC_W-1:0] rndSum   = acc[0] + rndHalf;
    wire [ACC_W-1:0] rndVal   = rndSum & ~rndMask;

    // RL11 byte length of the next one to three lines
    wire [PC_W-1:0]  len0     = PC_W'(skipInfo[0+:SKI_LEN_W]);
    wire [PC_W-1:0]  len1     = PC_W'(skipInfo[SKI_LEN_W+:SKI_LEN_W]);
    wire [PC_W-1:0]  len2     = PC_W'(skipInfo[2*SKI_LEN_W+:SKI_LEN_W]);
    wire [PC_W-1:0]  skipLen  = (cmd.skipLines == 2'h1) ? len0 :
                                (cmd.skipLines == 2'h2) ? len0 + len1 :
                                (cmd.skipLines == 2'h3) ? len0 + len1 + len2 : '0;

    // RL3 RL7 RL8 RL9 byte length of the instruction itself
    wire [PC_W-1:0]  ownBytes =
        isShRun                     ? (cmd.hasCount ? BYTES_TWO : BYTES_ONE) :
        (cmd.opcode == OP_SIGN)     ? BYTES_TWO   :
        (cmd.opcode == OP_ROUND)    ? BYTES_ROUND : BYTES_ONE;
    wire [PC_W-1:0]  pcStep   = ownBytes + ((cmd.opcode == OP_SKIP) ? skipLen : '0);

    // -----------------------------------------------------------------
    // apb response
    // -----------------------------------------------------------------
    // one wait state: pready rises in the first access cycle's edge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= firstAccess;
            pslverr <= firstAccess & next_err;
            prdata  <= (firstAccess & ~pwrite) ? next_rdata : 32'h00000000;
        end
    end

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= ST_IDLE;
            cmd        <= '0;
            cyclesLeft <= '0;
            stepsLeft  <= '0;
            runCycles  <= '0;
            lastCycles <= '0;
            busy       <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (launch)
                    begin
                        state      <= ST_EXEC;
                        cmd        <= newCmd;
                        cyclesLeft <= next_cyc;
                        runCycles  <= next_cyc;
                        // RL5 one step per count
                        stepsLeft  <= newCmd.hasCount ? {1'b0, newCmd.count} : 5'h01;
                        busy       <= 1'b1;
                    end
                end
                ST_EXEC:
                begin
                    if (doStep)
                    begin
                        stepsLeft <= stepsLeft - 5'h01;
                    end
                    cyclesLeft <= cyclesLeft - CYC_ONE;
                    if (lastCyc)
                    begin
                        state      <= ST_IDLE;
                        lastCycles <= runCycles;
                        busy       <= 1'b0;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // accumulators
    // -----------------------------------------------------------------
    // software writes only while idle, the unit only while running
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_ACC; i++)
            begin
                acc[i] <= '0;
            end
        end
        else if (wrNow & isAccReg)
        begin
            acc[regIdx] <= pwdata[ACC_W-1:0];
        end
        // RL12 any accumulator as operand
        else if (doStep)
        begin
            acc[cmd.accSel] <= stepVal;
        end
        else if (lastCyc & (cmd.opcode == OP_SIGN))
        begin
            acc[cmd.accSel] <= signVal;
        end
        // RL9 rounding result lands in x only
        else if (lastCyc & (cmd.opcode == OP_ROUND))
        begin
            acc[0] <= rndVal;
        end
    end

    // -----------------------------------------------------------------
    // flags
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags <= '0;
        end
        else if (wrNow & isFlags)
        begin
            flags <= pwdata[3:0];
        end
        // RL14 flags follow each step, the last one stays
        else if (doStep)
        begin
            flags.carry    <= stepOut[ACC_W];
            flags.overflow <= stepOvf;
            flags.sign     <= stepVal[ACC_W-1];
            flags.zero     <= (stepVal == '0);
        end
        // RL7 carry high, overflow low
        else if (lastCyc & (cmd.opcode == OP_FORCE_CARRY_HIGH))
        begin
            flags.carry    <= 1'b1;
            flags.overflow <= 1'b0;
        end
        // RL8 only s and z change
        else if (lastCyc & (cmd.opcode == OP_SIGN))
        begin
            flags.sign <= signVal[ACC_W-1];
            flags.zero <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // program counter and skip table
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            progCnt  <= '0;
            skipInfo <= 32'h00000000;
        end
        else
        begin
            if (wrNow & isSkipInf)
            begin
                skipInfo <= pwdata;
            end
            if (wrNow & isProgCnt)
            begin
                progCnt <= pwdata[PC_W-1:0];
            end
            // RL11 RL3 pc advances once the command ends
            else if (lastCyc)
            begin
                progCnt <= progCnt + pcStep;
            end
        end
    end

endmodule : srs_shift_rotate_sign_unit

// ===== tb/srs_sva.sv
// apb and busy-length assertions for the shift rotate sign unit
// assumes it is bound to the unit and shares its clock and reset
`timescale 1ns/1ps
module srs_sva
    import srs_pkg::*;
#(
    parameter logic [CYC_W-1:0] ROUND_CYCLES = 9'h004
)
(
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic              busy
);
    logic             done, launch;
    logic [CYC_W-1:0] steps, next_exp, expCyc, busyCnt;
    logic [7:0]       skipCyc;
    // refused transfers are left out so they cannot disturb the expected length
    assign done     = psel && penable && pready && !pslverr;
    assign launch   = done && pwrite && paddr == OFS_COMMAND;
    assign steps    = pwdata[CMD_HASC_BIT] ? 9'(pwdata[11:8]) + CYC_ONE : CYC_ONE;
    assign next_exp = (pwdata[3:0] <= OP_ARITHMETIC_RIGHT_SHIFT) ? steps :
                      (pwdata[3:0] == OP_SIGN) ? CYC_SIGN : (pwdata[3:0] == OP_ROUND) ?
                      ROUND_CYCLES : (pwdata[3:0] == OP_SKIP) ? 9'(skipCyc) + CYC_ONE : CYC_ONE;
    // count busy cycles from each launch; no reset needed, a launch always comes first
    always_ff @(posedge clock)
    begin
        expCyc  <= launch ? next_exp : expCyc;
        busyCnt <= launch ? 9'h000 : busyCnt + {8'h00, busy};
        skipCyc <= (done && pwrite && paddr == OFS_SKIP_INF) ? pwdata[23:16] : skipCyc;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_ready_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not after exactly one wait state");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_bad_addr_err: assert property (psel && penable && pready &&
        (paddr[1:0] != 2'h0 || paddr > OFS_STATUS) |-> pslverr)
        else $error("unmapped or misaligned access not refused");
    a_status_ro: assert property (psel && penable && pready && pwrite && paddr == OFS_STATUS
        |-> pslverr) else $error("write to status not refused");
    a_busy_refuse: assert property (psel && penable && !pready && pwrite && busy |=> pslverr)
        else $error("write while busy not refused");
    a_launch_busy: assert property (launch |=> busy)
        else $error("command launch did not raise busy");
    a_busy_length: assert property ($fell(busy) |-> busyCnt == expCyc)
        else $error("busy length differs from command cycle count");
    a_acc_width: assert property (done && !pwrite && paddr <= OFS_ACC_R
        |-> prdata[31:24] == 8'h00) else $error("accumulator upper byte not zero");
    c_skip: cover property (launch && pwdata[3:0] == OP_SKIP);
    c_refused: cover property (pslverr);
    c_long: cover property ($fell(busy) && busyCnt == 9'h010);
endmodule : srs_sva
bind srs_shift_rotate_sign_unit srs_sva #(.ROUND_CYCLES(ROUND_CYCLES)) srsSva (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .busy(busy));

// ===== tb/srs_seq_model.sv
// apb master standing in for the instruction decoder and sequencer
// assumes one clock with the unit; waits end only by the bench timeout
`timescale 1ns/1ps
module srs_seq_model
    import srs_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [31:0]            pwdata,
    input  wire logic              pready,
    input  wire logic [31:0]       prdata,
    input  wire logic              pslverr
);
    // idle bus from time zero
    initial {psel, penable, pwrite, paddr, pwdata} <= '0;
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        wait (rst_n === 1'b1);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        // request held until pready is seen at a rising edge
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        e = pslverr;
        // released lines show the inverse so a stale value is never trusted
        {psel, penable} <= 2'b00;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : srs_seq_model

// ===== tb/test_shift_rotate_sign_unit.sv
// self-checking bench for the shift rotate sign unit through its apb registers
// assumes the sequencer model as apb master and the bound assertion checker
`timescale 1ns/1ps
module test_shift_rotate_sign_unit
    import srs_pkg::*;
;
    logic              clock = 1'b0, rst_n = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr, busy;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    int                errors = 0, cmp_count = 0, cycles = 0;
    // 40 MHz clock
    initial forever #12.5 clock = ~clock;
    // short rounding call keeps the run brief
    srs_shift_rotate_sign_unit #(.ROUND_CYCLES(9'h003)) uut (.clock(clock), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy));
    srs_seq_model mst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // one transfer; on reads d is the expected word, skipped when refusal is expected
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic ee = 1'b0);
        logic [31:0] r;
        logic        e;
        mst.xfer(w, a, d, r, e);
        chk("slverr", {31'h0, ee}, {31'h0, e});
        if (!w && !ee)
            chk($sformatf("reg %h", a), d, r);
    endtask : acc
    task automatic idle();
        @(posedge clock);
        while (busy !== 1'b0) @(posedge clock);
    endtask : idle
    // load operand, flags and pc, run one command, then check all it may touch
    task automatic t(input logic [7:0] a, input logic [23:0] v, input logic [3:0] f,
        input logic [15:0] c, input logic [23:0] ev, input logic [3:0] ef,
        input logic [15:0] dp, input logic [8:0] n);
        acc(1'b1, a, {8'h00, v});
        acc(1'b1, OFS_FLAGS, {28'h0, f});
        acc(1'b1, OFS_PROG_CNT, 32'h00000010);
        acc(1'b1, OFS_COMMAND, {16'h0000, c});
        idle();
        acc(1'b0, a, {8'h00, ev});
        acc(1'b0, OFS_FLAGS, {28'h0, ef});
        acc(1'b0, OFS_PROG_CNT, 32'h00000010 + {16'h0000, dp});
        acc(1'b0, OFS_STATUS, {22'h0, n, 1'b0});
    endtask : t
    task automatic report_and_stop(input int hang);
        errors = errors + hang;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // a hang ends the run as a failure
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
            report_and_stop(1);
    end
    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        // every register reads zero after reset
        for (int i = 0; i < 9; i++)
            acc(1'b0, 8'(4 * i), 32'h0);
        acc(1'b1, OFS_ACC_Z, 32'hFFFFFFFF);
        acc(1'b0, OFS_ACC_Z, 32'h00FFFFFF); // upper byte dropped
        // unmapped, misaligned and read-only places are refused
        acc(1'b0, 8'h24, 32'h0, 1'b1);
        acc(1'b0, 8'h02, 32'h0, 1'b1);
        acc(1'b1, OFS_STATUS, 32'h00000001, 1'b1);
        acc(1'b0, OFS_STATUS, 32'h0);
        // operand, value, flags, command, result, flags, pc step, cycles
        t(OFS_ACC_Y, 24'h000003, 4'h1, 16'h0010, 24'h800001, 4'h7, 16'h1, 9'h1); // rot
        t(OFS_ACC_Z, 24'h000001, 4'h0, 16'h0360, 24'h400000, 4'h2, 16'h2, 9'h4); // rot
        t(OFS_ACC_R, 24'h800001, 4'h0, 16'h0031, 24'h000002, 4'h3, 16'h1, 9'h1); // shl
        t(OFS_ACC_X, 24'h400000, 4'h0, 16'h0241, 24'h000000, 4'hB, 16'h2, 9'h3); // shl
        t(OFS_ACC_Y, 24'h800003, 4'h0, 16'h0252, 24'hE00000, 4'h5, 16'h2, 9'h3); // sar
        t(OFS_ACC_Z, 24'h000002, 4'h0, 16'h0022, 24'h000001, 4'h0, 16'h1, 9'h1); // sar
        t(OFS_ACC_X, 24'h123456, 4'h6, 16'h0003, 24'h123456, 4'h5, 16'h1, 9'h1); // carry
        t(OFS_ACC_R, 24'h800000, 4'hB, 16'h0034, 24'hFFFFFF, 4'h7, 16'h2, 9'h2); // sign
        t(OFS_ACC_X, 24'h000000, 4'h0, 16'h0004, 24'h000001, 4'h0, 16'h2, 9'h2); // sign
        t(OFS_ACC_X, 24'h000017, 4'h9, 16'h0405, 24'h000010, 4'h9, 16'h7, 9'h3); // round
        t(OFS_ACC_X, 24'h000018, 4'h9, 16'h0405, 24'h000020, 4'h9, 16'h7, 9'h3); // round
        acc(1'b1, OFS_SKIP_INF, 32'h00050321);
        t(OFS_ACC_Y, 24'h0000AA, 4'h0, 16'h1006, 24'h0000AA, 4'h0, 16'h2, 9'h6); // skip
        t(OFS_ACC_Y, 24'h0000AA, 4'h0, 16'h3006, 24'h0000AA, 4'h0, 16'h7, 9'h6); // skip
        // a write during a long rotate is refused and leaves the operand alone
        acc(1'b1, OFS_ACC_X, 32'h00000001);
        acc(1'b1, OFS_COMMAND, 32'h00000F40);
        acc(1'b1, OFS_ACC_X, 32'h0, 1'b1);
        idle();
        acc(1'b0, OFS_ACC_X, 32'h00000400); // rotate result
        acc(1'b0, OFS_STATUS, 32'h00000020); // sixteen cycles
        // second reset while the unit is idle
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        acc(1'b0, OFS_ACC_X, 32'h0);
        acc(1'b0, OFS_STATUS, 32'h0); // last cycle count cleared
        report_and_stop(0);
    end
endmodule : test_shift_rotate_sign_unit
